// file: hc_sched_pkg.sv
// constants for the schedule, timeout and pio read pointer registers
package hc_sched_pkg;
    localparam logic [11:0] OFS_FILL_FLAGS    = 12'h334;
    localparam logic [11:0] OFS_DONE_TIMEOUT  = 12'h338;
    localparam logic [11:0] OFS_PIO_PTR       = 12'h33C;
    localparam logic [11:0] OFS_IRQ_STATUS    = 12'h348;
    localparam logic [11:0] OFS_IRQ_ENABLE    = 12'h34C;
    localparam logic [11:0] OFS_IRQ_CLEAR     = 12'h350;
    localparam logic [11:0] OFS_WALK_STATUS   = 12'h358;
    localparam int          BIT_ISO_FILLED    = 2;
    localparam int          BIT_INT_FILLED    = 1;
    localparam int          BIT_ASYNC_FILLED  = 0;
    localparam int          FILL_WIDTH        = 3;
    localparam int          BANK_LSB          = 16;
    localparam int          BANK_WIDTH        = 2;
    localparam int          ADDR_WIDTH        = 16;
    localparam int          NUM_BANKS         = 4;
    localparam int          NUM_SLOTS         = 32;
    localparam int          SLOT_WIDTH        = 5;
    localparam int          IRQ_TIMEOUT_BIT   = 0;
    localparam int          IRQ_WALK_BIT      = 1;
    localparam int          IRQ_WIDTH         = 2;
    localparam logic [31:0] RST_FILL_FLAGS    = 32'h0000_0000;
    localparam logic [31:0] RST_DONE_TIMEOUT  = 32'h0000_0000;
    localparam logic [31:0] RST_PIO_PTR       = 32'h0000_0000;
    localparam int          CLK_MHZ           = 250;
    localparam int          MS_PER_TICK       = 1;
    localparam int          CYCLES_PER_MS     = MS_PER_TICK * CLK_MHZ * 1000;
    typedef enum logic [1:0] {
        LIST_ISO   = 2'b00,
        LIST_INT   = 2'b01,
        LIST_ASYNC = 2'b10,
        LIST_IDLE  = 2'b11
    } list_sel_t;
endpackage

// file: ms_tick_gen.sv
// millisecond tick generator from the system clock
`timescale 1ns/1ns
module ms_tick_gen
    import hc_sched_pkg::*;
#(
    parameter int CYCLES = CYCLES_PER_MS
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    output logic      tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } tick_state_t;
    tick_state_t s_reg;
    tick_state_t s_next;
    localparam logic [31:0] LAST = 32'(CYCLES - 1);

    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (s_reg.cnt == LAST) begin
            s_next.cnt = 32'h0;
            s_next.tick = 1'b1;
        end else begin
            s_next.cnt = s_reg.cnt + 32'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    assign tick = s_reg.tick;

    a_tick_spacing: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tick |=> !tick) else $error("tick lasted more than one cycle");
endmodule

// file: pio_bank_ptrs.sv
// per-bank auto-incrementing pio read pointers
`timescale 1ns/1ns
module pio_bank_ptrs
    import hc_sched_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  load,
    input  wire logic [BANK_WIDTH-1:0] load_bank,
    input  wire logic [ADDR_WIDTH-1:0] load_addr,
    input  wire logic                  rd,
    input  wire logic [BANK_WIDTH-1:0] rd_bank,
    output logic [ADDR_WIDTH-1:0]      rd_addr
);
    typedef struct packed {
        logic [NUM_BANKS-1:0][ADDR_WIDTH-1:0] ptr;
    } ptr_state_t;
    ptr_state_t s_reg;
    ptr_state_t s_next;

    always_comb begin
        s_next = s_reg;
        for (int b = 0; b < NUM_BANKS; b++) begin
            if (load && load_bank == BANK_WIDTH'(b)) begin
                s_next.ptr[b] = load_addr;
            end else if (rd && rd_bank == BANK_WIDTH'(b)) begin
                s_next.ptr[b] = s_reg.ptr[b] + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    assign rd_addr = s_reg.ptr[rd_bank];

    a_ptr_increments: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rd && !load) |=> s_reg.ptr[$past(rd_bank)] == $past(rd_addr) + 16'h0001)
        else $error("bank pointer did not step on read");
    a_ptr_loads: assert property (@(posedge clk_sys) disable iff (!rst_n)
        load |=> s_reg.ptr[$past(load_bank)] == $past(load_addr))
        else $error("bank pointer did not take written address");
endmodule

// file: hc_sched_regs.sv
// host scheduler fill flags, async done timeout and pio read pointer registers
//
// What this block does
// - scheduler walks lists whose filled flag set
// - bit 2 gates isochronous area walk
// - bit 1 gates interrupt area walk
// - bit 0 gates asynchronous area walk
// - millisecond timeout raises enabled async-done interrupt
// - bank pointer latched, increments per bank read
// - bits 17:16 select one of four banks
// - bits 15:0 give pio read start address
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
module hc_sched_regs
    import hc_sched_pkg::*;
#(
    parameter int TICK_CYCLES = CYCLES_PER_MS
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic [11:0]           bus_addr,
    input  wire logic [31:0]           bus_wdata,
    input  wire logic                  bus_wr,
    input  wire logic                  bus_rd,
    output logic [31:0]                bus_rdata,
    input  wire logic [NUM_SLOTS-1:0]  slot_valid,
    input  wire logic [NUM_SLOTS-1:0]  slot_skip,
    input  wire logic                  async_done,
    input  wire logic                  pio_mode,
    input  wire logic                  pio_mem_rd,
    input  wire logic                  pio_mem_wr,
    output logic                       walk_active,
    output logic [1:0]                 walk_list,
    output logic [SLOT_WIDTH-1:0]      walk_slot,
    output logic                       walk_issue,
    output logic [BANK_WIDTH-1:0]      pio_bank,
    output logic [ADDR_WIDTH-1:0]      pio_addr,
    output logic                       pio_addr_valid,
    output logic                       irq
);
    typedef struct packed {
        logic [FILL_WIDTH-1:0]  fill;
        logic [31:0]            timeout;
        logic [BANK_WIDTH-1:0]  bank;
        logic [ADDR_WIDTH-1:0]  start;
        logic [31:0]            ms_count;
        logic                   pending;
        logic [IRQ_WIDTH-1:0]   status;
        logic [IRQ_WIDTH-1:0]   enable;
        list_sel_t              list;
        logic [SLOT_WIDTH-1:0]  slot;
        logic                   issue;
        logic [31:0]            rdata;
        logic [ADDR_WIDTH-1:0]  pio_addr;
        logic                   pio_valid;
        logic                   irq;
        logic                   active;
    } regs_state_t;
    regs_state_t s_reg;
    regs_state_t s_next;

    logic                  tick;
    logic [ADDR_WIDTH-1:0] bank_addr;
    logic                  ptr_load;
    logic                  bank_rd;

    ms_tick_gen #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tick    (tick)
    );

    assign ptr_load = bus_wr && bus_addr == OFS_PIO_PTR;
    assign bank_rd  = pio_mode && pio_mem_rd;

    pio_bank_ptrs u_ptrs (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .load      (ptr_load),
        .load_bank (bus_wdata[BANK_LSB +: BANK_WIDTH]),
        .load_addr (bus_wdata[ADDR_WIDTH-1:0]),
        .rd        (bank_rd),
        .rd_bank   (s_reg.bank),
        .rd_addr   (bank_addr)
    );

    function automatic list_sel_t next_list(input list_sel_t from, input logic [FILL_WIDTH-1:0] f);
        list_sel_t r;
        r = LIST_IDLE;
        unique case (from)
            LIST_IDLE, LIST_ASYNC: begin
                if (f[BIT_ISO_FILLED]) r = LIST_ISO;
                else if (f[BIT_INT_FILLED]) r = LIST_INT;
                else if (f[BIT_ASYNC_FILLED]) r = LIST_ASYNC;
            end
            LIST_ISO: begin
                if (f[BIT_INT_FILLED]) r = LIST_INT;
                else if (f[BIT_ASYNC_FILLED]) r = LIST_ASYNC;
                else if (f[BIT_ISO_FILLED]) r = LIST_ISO;
            end
            LIST_INT: begin
                if (f[BIT_ASYNC_FILLED]) r = LIST_ASYNC;
                else if (f[BIT_ISO_FILLED]) r = LIST_ISO;
                else if (f[BIT_INT_FILLED]) r = LIST_INT;
            end
        endcase
        return r;
    endfunction

    logic list_on;
    logic [IRQ_WIDTH-1:0] ev;

    always_comb begin
        s_next = s_reg;
        ev = '0;
        s_next.issue = 1'b0;
        s_next.rdata = 32'h0000_0000;
        // register writes
        if (bus_wr) begin
            unique case (bus_addr)
                OFS_FILL_FLAGS:   s_next.fill = bus_wdata[FILL_WIDTH-1:0];
                OFS_DONE_TIMEOUT: s_next.timeout = bus_wdata;
                OFS_PIO_PTR: begin
                    s_next.bank = bus_wdata[BANK_LSB +: BANK_WIDTH];
                    s_next.start = bus_wdata[ADDR_WIDTH-1:0];
                end
                OFS_IRQ_ENABLE:   s_next.enable = bus_wdata[IRQ_WIDTH-1:0];
                default: ;
            endcase
        end
        // list walk: only areas whose flag is set are visited
        list_on = 1'b0;
        unique case (s_reg.list)
            LIST_ISO:   list_on = s_reg.fill[BIT_ISO_FILLED];
            LIST_INT:   list_on = s_reg.fill[BIT_INT_FILLED];
            LIST_ASYNC: list_on = s_reg.fill[BIT_ASYNC_FILLED];
            LIST_IDLE:  list_on = 1'b0;
        endcase
        if (!list_on) begin
            s_next.list = next_list(s_reg.list, s_reg.fill);
            s_next.slot = '0;
        end else begin
            s_next.issue = slot_valid[s_reg.slot] && !slot_skip[s_reg.slot];
            s_next.slot = s_reg.slot + 5'h01;
            if (s_reg.slot == 5'h1F) begin
                s_next.list = next_list(s_reg.list, s_reg.fill);
            end
        end
        // async done timeout in ms ticks, restarts on every completion
        if (async_done) begin
            s_next.pending = 1'b1;
            s_next.ms_count = 32'h0;
        end else if (s_reg.pending && tick) begin
            if (s_reg.ms_count + 32'h1 >= s_reg.timeout) begin
                s_next.pending = 1'b0;
                ev[IRQ_TIMEOUT_BIT] = 1'b1;
            end else begin
                s_next.ms_count = s_reg.ms_count + 32'h1;
            end
        end
        ev[IRQ_WALK_BIT] = s_reg.list != LIST_IDLE && s_next.list == LIST_IDLE;
        s_next.active = s_next.list != LIST_IDLE;
        // clear first, set wins
        if (bus_wr && bus_addr == OFS_IRQ_CLEAR) begin
            s_next.status = s_reg.status & ~bus_wdata[IRQ_WIDTH-1:0];
        end
        s_next.status = s_next.status | ev;
        s_next.irq = |(s_next.status & s_next.enable);
        // pio read address, valid in pio mode reads and writes to the selected bank
        s_next.pio_addr = bank_addr;
        s_next.pio_valid = pio_mode && (pio_mem_rd || pio_mem_wr);
        // reads
        if (bus_rd) begin
            unique case (bus_addr)
                OFS_FILL_FLAGS:   s_next.rdata = {29'h0, s_reg.fill};
                OFS_DONE_TIMEOUT: s_next.rdata = s_reg.timeout;
                OFS_PIO_PTR:      s_next.rdata = {14'h0, s_reg.bank, s_reg.start};
                OFS_IRQ_STATUS:   s_next.rdata = {30'h0, s_reg.status};
                OFS_IRQ_ENABLE:   s_next.rdata = {30'h0, s_reg.enable};
                OFS_WALK_STATUS:  s_next.rdata = {22'h0, s_reg.slot, 3'h0, s_reg.list};
                default:          s_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.fill <= RST_FILL_FLAGS[FILL_WIDTH-1:0];
            s_reg.timeout <= RST_DONE_TIMEOUT;
            s_reg.bank <= RST_PIO_PTR[BANK_LSB +: BANK_WIDTH];
            s_reg.start <= RST_PIO_PTR[ADDR_WIDTH-1:0];
            s_reg.list <= LIST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus_rdata      = s_reg.rdata;
    assign walk_active    = s_reg.active;
    assign walk_list      = s_reg.list;
    assign walk_slot      = s_reg.slot;
    assign walk_issue     = s_reg.issue;
    assign pio_bank       = s_reg.bank;
    assign pio_addr       = s_reg.pio_addr;
    assign pio_addr_valid = s_reg.pio_valid;
    assign irq            = s_reg.irq;

    a_iso_skipped: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (s_reg.list == LIST_ISO && !s_reg.fill[BIT_ISO_FILLED]) |=> !walk_issue)
        else $error("iso area walked while not filled");
    a_int_skipped: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (s_reg.list == LIST_INT && !s_reg.fill[BIT_INT_FILLED]) |=> !walk_issue)
        else $error("int area walked while not filled");
    a_async_skipped: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (s_reg.list == LIST_ASYNC && !s_reg.fill[BIT_ASYNC_FILLED]) |=> !walk_issue)
        else $error("async area walked while not filled");
    a_issue_valid_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
        walk_issue |-> $past(slot_valid[s_reg.slot]) && !$past(slot_skip[s_reg.slot]))
        else $error("skipped or invalid descriptor issued");
    a_walk_starts: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (s_reg.list == LIST_IDLE && s_reg.fill != 3'h0 && !bus_wr) |=> walk_active)
        else $error("filled list not walked");
    a_timeout_irq: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ev[IRQ_TIMEOUT_BIT] && s_reg.enable[IRQ_TIMEOUT_BIT] |=> irq)
        else $error("timeout did not raise irq");
    a_bank_field: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ptr_load |=> pio_bank == $past(bus_wdata[17:16]))
        else $error("bank select not taken from bits 17:16");
    a_start_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ptr_load ##2 (bus_rd && bus_addr == OFS_PIO_PTR) |=> bus_rdata[15:0] == $past(bus_wdata[15:0], 3))
        else $error("start address readback wrong");
endmodule

// file: desc_area_model.sv
// descriptor area model: slot valid and skip marks of the list being walked
`timescale 1ns/1ns
module desc_area_model
    import hc_sched_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic [1:0]           walk_list,
    output logic      [NUM_SLOTS-1:0] slot_valid,
    output logic      [NUM_SLOTS-1:0] slot_skip
);
    logic [NUM_SLOTS-1:0] valid_mask [3] = '{default: 32'h0};
    logic [NUM_SLOTS-1:0] skip_mask  [3] = '{default: 32'h0};
    logic                 idle_flip      = 1'b0;

    task automatic load(input int list, input logic [31:0] v, input logic [31:0] s);
        valid_mask[list] = v;
        skip_mask[list]  = s;
    endtask

    always @(posedge clk_sys) begin
        idle_flip <= ~idle_flip;
    end

    // no area selected: lines keep changing so a stale sample shows up
    always_comb begin
        if (walk_list == 2'h3) begin
            slot_valid = {NUM_SLOTS{idle_flip}};
            slot_skip  = {NUM_SLOTS{~idle_flip}};
        end else begin
            slot_valid = valid_mask[walk_list];
            slot_skip  = skip_mask[walk_list];
        end
    end
endmodule

// file: tb.sv
// self-checking bench for fill flags, done timeout and pio read pointer
`timescale 1ns/1ns
module tb
    import hc_sched_pkg::*;
;
    localparam int TICKS = 10;
    logic                  clk_sys    = 1'b0;
    logic                  rst_n      = 1'b0;
    logic [11:0]           bus_addr   = 12'h000;
    logic [31:0]           bus_wdata  = 32'h0;
    logic                  bus_wr     = 1'b0;
    logic                  bus_rd     = 1'b0;
    logic                  async_done = 1'b0;
    logic                  pio_mode   = 1'b0;
    logic                  pio_mem_rd = 1'b0;
    logic                  pio_mem_wr = 1'b0;
    logic [31:0]           bus_rdata;
    logic [NUM_SLOTS-1:0]  slot_valid, slot_skip;
    logic                  walk_active, walk_issue, pio_addr_valid, irq;
    logic [1:0]            walk_list, pio_bank, prev_list;
    logic [SLOT_WIDTH-1:0] walk_slot, prev_slot;
    logic [ADDR_WIDTH-1:0] pio_addr;
    logic [31:0]           seed, vm [3], sm [3], seen [3];
    logic [2:0]            allowed = 3'h0;
    logic                  pv_exp  = 1'b0;
    int                    err_count = 0, num_checks = 0, cycles = 0;

    hc_sched_regs #(
        .TICK_CYCLES(TICKS)
    ) i_hc_sched_regs (
        .clk_sys, .rst_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
        .slot_valid, .slot_skip, .async_done, .pio_mode, .pio_mem_rd, .pio_mem_wr,
        .walk_active, .walk_list, .walk_slot, .walk_issue, .pio_bank, .pio_addr,
        .pio_addr_valid, .irq
    );
    desc_area_model i_desc_area_model (
        .clk_sys, .walk_list, .slot_valid, .slot_skip
    );

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string name);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1;
        chk(name, exp, bus_rdata);
        @(posedge clk_sys);
    endtask

    task automatic pulse_done();
        async_done <= 1'b1;
        @(posedge clk_sys);
        async_done <= 1'b0;
        @(posedge clk_sys);
    endtask

    // issue seen now belongs to the list and slot walked one cycle before
    always @(posedge clk_sys) begin
        cycles++;
        if (rst_n) begin
            chk("pio_addr_valid", {31'h0, pv_exp}, {31'h0, pio_addr_valid});
            if (walk_issue === 1'b1 && prev_list < 2'h3) begin
                seen[prev_list][prev_slot] = 1'b1;
            end
        end
        pv_exp    = pio_mode & (pio_mem_rd | pio_mem_wr);
        prev_list = walk_list;
        prev_slot = walk_slot;
        if (cycles > 5000) begin
            err_count++;
            report_and_stop();
        end
    end

    initial begin
        logic [31:0] d, v;
        int          n;
        seed = 32'hC8F4495A;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk("walk_list_rst", 32'h3, {30'h0, walk_list});
        rdc(OFS_FILL_FLAGS, RST_FILL_FLAGS, "fill_rst");
        rdc(OFS_DONE_TIMEOUT, RST_DONE_TIMEOUT, "tmo_rst");
        rdc(OFS_PIO_PTR, RST_PIO_PTR, "ptr_rst");
        rdc(12'h100, 32'h0, "unmapped");
        d = rnd();
        wr(OFS_DONE_TIMEOUT, d);
        rdc(OFS_DONE_TIMEOUT, d, "tmo_rw");
        // three ms ticks after a completion, then masked, then cleared
        wr(OFS_DONE_TIMEOUT, 32'h3);
        pulse_done();
        wr(OFS_IRQ_CLEAR, 32'h1);
        wr(OFS_IRQ_ENABLE, 32'h1);
        cyc(8);
        #1;
        chk("irq_early", 32'h0, {31'h0, irq});
        n = 0;
        while (irq !== 1'b1 && n < 40) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk("irq_fire", 32'h1, {31'h0, irq});
        wr(OFS_IRQ_ENABLE, 32'h0);
        #1;
        chk("irq_masked", 32'h0, {31'h0, irq});
        rdc(OFS_IRQ_STATUS, 32'h1, "tmo_status");
        wr(OFS_DONE_TIMEOUT, 32'hFFFFFFFF);
        pulse_done();
        wr(OFS_IRQ_CLEAR, 32'h1);
        rdc(OFS_IRQ_STATUS, 32'h0, "tmo_clear");
        rdc(OFS_IRQ_CLEAR, 32'h0, "clear_reads_0");
        for (int l = 0; l < 3; l++) begin
            vm[l] = rnd();
            sm[l] = rnd();
            i_desc_area_model.load(l, vm[l], sm[l]);
        end
        // iso alone, int alone, async alone, then all three
        for (int k = 0; k < 4; k++) begin
            d = (k == 3) ? 32'h7 : (32'h4 >> k);
            allowed = {d[0], d[1], d[2]};
            seen = '{default: 32'h0};
            wr(OFS_FILL_FLAGS, d);
            rdc(OFS_FILL_FLAGS, d, "fill_rw");
            cyc(250);
            chk("walk_active_on", 32'h1, {31'h0, walk_active});
            wr(OFS_FILL_FLAGS, 32'h0);
            cyc(60);
            chk("walk_active_off", 32'h0, {31'h0, walk_active});
            for (int l = 0; l < 3; l++) begin
                chk("walk_seen", allowed[l] ? vm[l] & ~sm[l] : 32'h0, seen[l]);
            end
        end
        wr(OFS_IRQ_ENABLE, 32'h2);
        #1;
        chk("irq_walk", 32'h1, {31'h0, irq});
        wr(OFS_IRQ_CLEAR, 32'h2);
        rdc(OFS_IRQ_STATUS, 32'h0, "walk_clear");
        #1;
        chk("irq_cleared", 32'h0, {31'h0, irq});
        // per bank: load, burst of reads, a write in pio mode and a read outside pio mode
        for (int b = 0; b < 4; b++) begin
            v = (b == 3) ? 32'hFFFE : rnd() & 32'hFFFF;
            d = {14'h0, b[1:0], v[15:0]};
            wr(OFS_PIO_PTR, d);
            rdc(OFS_PIO_PTR, d, "ptr_rw");
            n = 1 + rnd() % 5;
            pio_mode   <= 1'b1;
            pio_mem_rd <= 1'b1;
            cyc(n);
            pio_mem_rd <= 1'b0;
            pio_mem_wr <= 1'b1;
            cyc(1);
            pio_mode   <= 1'b0;
            pio_mem_wr <= 1'b0;
            pio_mem_rd <= 1'b1;
            cyc(1);
            pio_mem_rd <= 1'b0;
            cyc(3);
            #1;
            chk("pio_bank", b, {30'h0, pio_bank});
            chk("pio_addr", (v + n) & 32'hFFFF, {16'h0, pio_addr});
        end
        report_and_stop();
    end
endmodule
